/* apgc_channel.v */
`timescale 1ns/100ps
`include "apgc_defs.vh"

// ----------------------------------------------------------------
// Per-channel gain decode and thermometer quantizer
// ----------------------------------------------------------------
module apgc_channel (
  input wire core_clk_i,
  input wire rst_i,
  input wire run_i,
  input wire sample_i,
  input wire [2:0] channel_gain_code_i,
  input wire [3:0] comp_raw_i,
  output reg [5:0] gain_sel_o,
  output reg [3:0] thermo_o,
  output reg [2:0] level_o
);

  reg [3:0] thermo_next;
  reg [5:0] gain_next;

  // Gain decode; unassigned codes fall back to unity
  always @* begin
    case (channel_gain_code_i)
      // R8: gain code table
      `APGC_GAIN_X1: gain_next = 6'h01;
      `APGC_GAIN_X2: gain_next = 6'h02;
      `APGC_GAIN_X4: gain_next = 6'h04;
      `APGC_GAIN_X8: gain_next = 6'h08;
      `APGC_GAIN_X16: gain_next = 6'h10;
      `APGC_GAIN_X32: gain_next = 6'h20;
      // R9: codes 6, 7 unity
      default: gain_next = `APGC_GAIN_SEL_X1;
    endcase
  end

  // Force a clean thermometer code so bubbles never reach the DAC
  always @* begin
    // R10: thermometer from four comparators
    thermo_next = {comp_raw_i[3] & comp_raw_i[2] & comp_raw_i[1]
                   & comp_raw_i[0],
                   comp_raw_i[2] & comp_raw_i[1] & comp_raw_i[0],
                   comp_raw_i[1] & comp_raw_i[0],
                   comp_raw_i[0]};
  end

  // Quantizer register, refreshed once per modulator clock
  always @(posedge core_clk_i) begin
    gain_sel_o <= gain_next;
    if (rst_i) begin
      // R12: comparator reset pattern
      thermo_o <= `APGC_THERMO_RESET;
      level_o <= 3'h2;
      gain_sel_o <= `APGC_GAIN_SEL_X1;
    end else if (run_i && sample_i) begin
      // R11: one update per modulator clock
      thermo_o <= thermo_next;
      level_o <= {2'h0, thermo_next[0]} + {2'h0, thermo_next[1]}
                 + {2'h0, thermo_next[2]} + {2'h0, thermo_next[3]};
    end
  end

endmodule // apgc_channel

/* apgc_defs.vh */
`ifndef APGC_DEFS_VH
`define APGC_DEFS_VH

// ----------------------------------------------------------------
// Gain code encodings
// ----------------------------------------------------------------
`define APGC_GAIN_CODE_W 3
`define APGC_GAIN_X1 3'h0
`define APGC_GAIN_X2 3'h1
`define APGC_GAIN_X4 3'h2
`define APGC_GAIN_X8 3'h3
`define APGC_GAIN_X16 3'h4
`define APGC_GAIN_X32 3'h5
// One-hot gain select, bit n means gain 2**n
`define APGC_GAIN_SEL_W 6
`define APGC_GAIN_SEL_X1 6'h01

// ----------------------------------------------------------------
// Quantizer and modulator timing
// ----------------------------------------------------------------
`define APGC_THERMO_W 4
`define APGC_THERMO_RESET 4'h3
`define APGC_NUM_CH 2
`define APGC_SD_ALL 2'h3
// Master clock to modulator clock ratio: 4 MHz in, 1 MHz out
`define APGC_MCLK_KHZ 4000
`define APGC_MODULATOR_SAMPLE_CLOCK_KHZ 1000
`define APGC_MODULATOR_SAMPLE_CLOCK_DIV (`APGC_MCLK_KHZ / `APGC_MODULATOR_SAMPLE_CLOCK_KHZ)
`define APGC_DIV_W 2
// Last divider count; parking here makes a restart begin a full phase
`define APGC_DIV_LAST 2'h3

`endif

/* apgc_host_model.sv */
`timescale 1ns/100ps
// ----
// Host
// ----
module apgc_host_model (
  input wire core_clk_i,
  input wire wr_i,
  input wire [4:0] cfg_i,
  output reg spi_mode_o,
  output reg [1:0] shutdown_o,
  output reg ext_ref_o,
  output reg ext_clk_o
);
  // host SPI mode follows cfg_i[4], starting cleared
  // Settings land on the falling edge, clear of the sampling edge
  initial {spi_mode_o, shutdown_o, ext_ref_o, ext_clk_o} = 5'h00;
  always @(negedge core_clk_i) begin
    if (wr_i) begin
      {spi_mode_o, shutdown_o, ext_ref_o, ext_clk_o} <= cfg_i;
    end
  end
endmodule // apgc_host_model

/* apgc_top.v */
`timescale 1ns/100ps
`include "apgc_defs.vh"

// Contract
// R1: Full low-power needs both shutdown bits 11 and both external selects 1.
// R2: Full low-power disables both supply monitors and stops all clocks.
// R3: Full low-power holds both converters off and the reference off.
// R4: Full low-power is only reachable in SPI mode, which the host must use.
// R5: Full low-power also withholds the clock from the input structure.
// R6: The serial interface stays alive in full low-power.
// R7: Clearing any controlling bit restores both supply monitors.
// R8: Each channel has a 3-bit gain code, 0..5 giving gains 1..32.
// R9: Gain codes 6 and 7 act as gain 1.
// R10: Each quantizer is four comparators giving a thermometer code.
// R11: Modulators update once per modulator clock, master divided by 4.
// R12: Hard reset forces comparators to 0011 and clears filters.
// R13: All converters shut down stops core and input clocks until one runs.
// R14: The low-power decode is combinational from the stored bits.

module apgc_top (
  input wire core_clk_i,
  input wire rst_i,
  input wire spi_mode_i,
  input wire [1:0] shutdown_i,
  input wire external_reference_select_i,
  input wire external_clock_select_i,
  input wire [2:0] channel_gain_code_0_i,
  input wire [2:0] channel_gain_code_1_i,
  input wire [3:0] comp_raw_0_i,
  input wire [3:0] comp_raw_1_i,
  output reg full_shutdown_o,
  output reg avdd_por_en_o,
  output reg dvdd_por_en_o,
  output reg [1:0] adc_enable_o,
  output reg vref_int_en_o,
  output reg input_clk_en_o,
  output reg core_clk_en_o,
  output reg spi_active_o,
  output reg modulator_sample_clock_o,
  output reg [1:0] filter_clear_o,
  output reg [5:0] gain_sel_0_o,
  output reg [5:0] gain_sel_1_o,
  output reg [3:0] thermo_0_o,
  output reg [3:0] thermo_1_o,
  output reg [2:0] level_0_o,
  output reg [2:0] level_1_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Comparator outputs are analog-side, so they cross two flops
  reg [7:0] comp_meta_reg;
  reg [7:0] comp_sync_reg;

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      comp_meta_reg <= 8'h00;
      comp_sync_reg <= 8'h00;
    end else begin
      comp_meta_reg <= {comp_raw_1_i, comp_raw_0_i};
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Low-power decode
  // ----------------------------------------------------------------
  // Config bits arrive from the register file on this clock
  wire full_sd;
  wire all_sd;

  // R14: combinational decode
  // R1: entry condition
  // R4: SPI mode only
  assign full_sd = spi_mode_i && (shutdown_i == `APGC_SD_ALL)
                   && external_reference_select_i
                   && external_clock_select_i;
  // R13: all converters off
  assign all_sd = (shutdown_i == `APGC_SD_ALL);

  // ----------------------------------------------------------------
  // Modulator clock divider
  // ----------------------------------------------------------------
  reg [1:0] div_reg;
  reg [1:0] div_next;
  wire sample_tick;
  wire run;

  assign run = ~all_sd;
  assign sample_tick = (div_reg == 2'h0);

  // Divider parks on its last count while stopped, so the first
  // modulator clock after reset or a restart is never a short pulse
  always @* begin
    div_next = `APGC_DIV_LAST;
    if (run) begin
      if (div_reg == `APGC_DIV_LAST)
        div_next = 2'h0;
      else
        div_next = div_reg + 2'h1;
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      div_reg <= `APGC_DIV_LAST;
    end else begin
      div_reg <= div_next;
    end
  end

  // ----------------------------------------------------------------
  // Power and clock control outputs
  // ----------------------------------------------------------------
  // Registered one stage after the decode; outputs must come from flops
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      full_shutdown_o <= 1'b0;
      avdd_por_en_o <= 1'b1;
      dvdd_por_en_o <= 1'b1;
      adc_enable_o <= 2'h0;
      vref_int_en_o <= 1'b1;
      input_clk_en_o <= 1'b1;
      core_clk_en_o <= 1'b1;
      spi_active_o <= 1'b0;
      modulator_sample_clock_o <= 1'b0;
      filter_clear_o <= 2'h3;
    end else begin
      full_shutdown_o <= full_sd;
      // R2: monitors off in full low-power
      // R7: monitors back once any bit clears
      avdd_por_en_o <= ~full_sd;
      dvdd_por_en_o <= ~full_sd;
      // R3: converters held off
      adc_enable_o <= full_sd ? 2'h0 : ~shutdown_i;
      // R3: reference off
      vref_int_en_o <= ~full_sd;
      // R5: input clock withheld
      // R13: input clock gated
      input_clk_en_o <= ~(full_sd | all_sd);
      // R2: no clock propagates
      // R13: core clock gated
      core_clk_en_o <= ~(full_sd | all_sd);
      // R6: serial interface kept alive
      spi_active_o <= 1'b1;
      // R11: half-duty modulator clock
      modulator_sample_clock_o <= run && (div_next < 2'h2);
      // R12: filters cleared while converter is off
      filter_clear_o <= shutdown_i;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  wire [5:0] gsel0;
  wire [5:0] gsel1;
  wire [3:0] th0;
  wire [3:0] th1;
  wire [2:0] lv0;
  wire [2:0] lv1;

  apgc_channel u_ch0 (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .run_i(~shutdown_i[0]),
    .sample_i(sample_tick),
    .channel_gain_code_i(channel_gain_code_0_i),
    .comp_raw_i(comp_sync_reg[3:0]),
    .gain_sel_o(gsel0),
    .thermo_o(th0),
    .level_o(lv0)
  );

  apgc_channel u_ch1 (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .run_i(~shutdown_i[1]),
    .sample_i(sample_tick),
    .channel_gain_code_i(channel_gain_code_1_i),
    .comp_raw_i(comp_sync_reg[7:4]),
    .gain_sel_o(gsel1),
    .thermo_o(th1),
    .level_o(lv1)
  );

  // Top outputs straight from flops; adds one cycle of latency
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      gain_sel_0_o <= `APGC_GAIN_SEL_X1;
      gain_sel_1_o <= `APGC_GAIN_SEL_X1;
      thermo_0_o <= `APGC_THERMO_RESET;
      thermo_1_o <= `APGC_THERMO_RESET;
      level_0_o <= 3'h2;
      level_1_o <= 3'h2;
    end else begin
      gain_sel_0_o <= gsel0;
      gain_sel_1_o <= gsel1;
      thermo_0_o <= th0;
      thermo_1_o <= th1;
      level_0_o <= lv0;
      level_1_o <= lv1;
    end
  end

endmodule // apgc_top

/* apgc_top_sva.sv */
`timescale 1ns/100ps
module apgc_top_sva (
  input wire core_clk_i,
  input wire rst_i,
  input wire spi_mode_i,
  input wire [1:0] shutdown_i,
  input wire external_reference_select_i,
  input wire external_clock_select_i,
  input wire [2:0] channel_gain_code_0_i,
  input wire full_shutdown_o,
  input wire avdd_por_en_o,
  input wire dvdd_por_en_o,
  input wire [1:0] adc_enable_o,
  input wire vref_int_en_o,
  input wire input_clk_en_o,
  input wire spi_active_o,
  input wire modulator_sample_clock_o,
  input wire [1:0] filter_clear_o,
  input wire [5:0] gain_sel_0_o,
  input wire [3:0] thermo_0_o,
  input wire [2:0] level_0_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire all_set = &shutdown_i && external_reference_select_i &&
    external_clock_select_i;
  chk_entry_decode: assert property (!$past(rst_i) |->
    full_shutdown_o == $past(all_set && spi_mode_i)) else $error("entry");
  chk_por_off: assert property (full_shutdown_o |->
    !avdd_por_en_o && !dvdd_por_en_o) else $error("por on");
  chk_conv_off: assert property (full_shutdown_o |->
    adc_enable_o == 2'h0 && !vref_int_en_o) else $error("conv on");
  chk_clk_gate: assert property (!$past(rst_i) |->
    input_clk_en_o == !(&$past(shutdown_i))) else $error("clk gate");
  chk_spi_alive: assert property (!$past(rst_i) |-> spi_active_o)
    else $error("spi idle");
  chk_por_back: assert property (full_shutdown_o && !all_set |=>
    avdd_por_en_o && dvdd_por_en_o) else $error("por back");
  chk_gain_map: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
    gain_sel_0_o == ($past(channel_gain_code_0_i, 2) < 3'h6 ?
    6'h01 << $past(channel_gain_code_0_i, 2) : 6'h01)) else $error("gain");
  chk_thermo_form: assert property (level_0_o == $countones(thermo_0_o) &&
    thermo_0_o inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf}) else $error("thermo");
  // Divider parks on its last count while both converters are shut down; cycles with any shutdown bit set are left out
  chk_mod_period: assert property (disable iff (rst_i || |shutdown_i)
    $rose(modulator_sample_clock_o) |=> modulator_sample_clock_o ##1
    !modulator_sample_clock_o [*2] ##1 modulator_sample_clock_o)
    else $error("mod clk");
  chk_reset_pattern: assert property ($fell(rst_i) |->
    thermo_0_o == 4'h3 && filter_clear_o == 2'h3) else $error("reset");
endmodule // apgc_top_sva
bind apgc_top apgc_top_sva apgc_top_sva_inst (.*);

/* tb.sv */
`timescale 1ns/100ps
module tb;
  reg core_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wr = 1'b0;
  reg [4:0] cfg = 5'h00;
  reg [2:0] g0 = 3'h0, g1 = 3'h0;
  reg [3:0] c0 = 4'h0, c1 = 4'h0;
  wire spi, rs, cs, fs, ap, dp, vr, ic, cc, sa, mc;
  wire [1:0] sd, ae, fc;
  wire [5:0] gs0, gs1;
  wire [3:0] t0, t1;
  wire [2:0] l0, l1;
  integer error_cnt = 0, check_count = 0, cyc = 0, i, n;
  apgc_host_model apgc_host_model_inst (.core_clk_i(core_clk_i), .wr_i(wr),
    .cfg_i(cfg), .spi_mode_o(spi), .shutdown_o(sd), .ext_ref_o(rs),
    .ext_clk_o(cs));
  apgc_top apgc_top_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .spi_mode_i(spi), .shutdown_i(sd), .external_reference_select_i(rs),
    .external_clock_select_i(cs), .channel_gain_code_0_i(g0),
    .channel_gain_code_1_i(g1), .comp_raw_0_i(c0), .comp_raw_1_i(c1),
    .full_shutdown_o(fs), .avdd_por_en_o(ap), .dvdd_por_en_o(dp),
    .adc_enable_o(ae), .vref_int_en_o(vr), .input_clk_en_o(ic),
    .core_clk_en_o(cc), .spi_active_o(sa), .modulator_sample_clock_o(mc),
    .filter_clear_o(fc), .gain_sel_0_o(gs0), .gain_sel_1_o(gs1),
    .thermo_0_o(t0), .thermo_1_o(t1), .level_0_o(l0), .level_1_o(l1));
  initial forever #10 core_clk_i = ~core_clk_i;
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      end_sim;
    end
  end
  task check(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Bits: spi mode, shutdown[1:0], reference select, clock select
  task set_cfg(input [4:0] v);
    begin
      @(negedge core_clk_i) cfg <= v;
      wr <= 1'b1;
      @(negedge core_clk_i) wr <= 1'b0;
      repeat (2) @(negedge core_clk_i);
    end
  endtask
  function [7:0] pw(input [4:0] v);
    reg f;
    begin
      f = v[4] & (v[3:2] == 2'h3) & v[1] & v[0];
      pw = {f, ~f, ~f, ~f, ~&v[3:2], ~&v[3:2], f ? 2'h0 : ~v[3:2]};
    end
  endfunction
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(negedge core_clk_i);
    check({sa, fc, t0, 1'b0}, 8'h66);
    rst_i <= 1'b0;
    $display("reset test done");
    // Every setting entered from full low-power, so each exit is seen
    for (i = 0; i < 32; i = i + 1) begin
      set_cfg(5'h1f);
      check({7'h00, sa}, 8'h01);
      set_cfg(i[4:0]);
      check({fs, ap, dp, vr, ic, cc, ae}, pw(i[4:0]));
    end
    $display("power test done");
    for (i = 0; i < 8; i = i + 1) begin
      @(negedge core_clk_i) g0 <= i[2:0];
      g1 <= 3'h7 - i[2:0];
      repeat (3) @(negedge core_clk_i);
      check({2'h0, gs0}, i < 6 ? 8'h01 << i : 8'h01);
      check({2'h0, gs1}, i > 1 ? 8'h01 << (7 - i) : 8'h01);
    end
    $display("gain test done");
    set_cfg(5'h10);
    @(negedge core_clk_i) c0 <= 4'hf;
    // Bubbled pattern must still give a clean one-step code
    c1 <= 4'h5;
    repeat (16) @(negedge core_clk_i);
    check({t0, 1'b0, l0}, 8'hf4);
    check({t1, 1'b0, l1}, 8'h11);
    n = 0;
    for (i = 0; i < 40; i = i + 1) begin
      @(negedge core_clk_i) n = n + mc;
    end
    check(n[7:0], 8'h14);
    $display("modulator test done");
    end_sim;
  end
endmodule // tb
